// *** inc/cbe_pkg.sv ***
// ----------------------------------------------------------------
// Shared constants for the cache and bus event counting block
// ----------------------------------------------------------------
package cbe_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_SELECT = 4'h0;  // Event code and unit mask
  localparam logic [3:0] OFS_COUNT  = 4'h4;  // Event counter
  localparam logic [3:0] OFS_STATUS = 4'h8;  // Bus tracker state
  // Select register field positions
  localparam int SEL_CODE_LSB = 0;   // Event code [7:0]
  localparam int SEL_MASK_LSB = 8;   // Unit mask [15:8]
  localparam int SEL_EN_BIT   = 16;  // Counter enable
  // Reset values
  localparam logic [31:0] SELECT_RST = 32'h0000_0000;
  // Event codes
  localparam logic [7:0] EV_PF_MISS   = 8'h4B;  // Software prefetch total miss
  localparam logic [7:0] EV_LOAD_HIT  = 8'h4C;  // Load hits in-flight prefetch
  localparam logic [7:0] EV_L1_PFREQ  = 8'h4E;  // First-level prefetch requests
  localparam logic [7:0] EV_RD_OUTST  = 8'h60;  // Outstanding line reads
  localparam logic [7:0] EV_BNR_DRV   = 8'h61;  // Not-ready assertions
  localparam logic [7:0] EV_DATA_READY_STROBE_CYC  = 8'h62;  // Data strobe cycles
  // Unit masks
  localparam logic [7:0] UM_L0_MISS   = 8'h01;
  localparam logic [7:0] UM_L12_MISS  = 8'h02;
  localparam logic [7:0] UM_NONE      = 8'h00;
  localparam logic [7:0] UM_PF_REQ    = 8'h10;
  localparam logic [7:0] UM_AGENT_OWN = 8'h40;
  localparam logic [7:0] UM_AGENT_ANY = 8'hC0;
  // Prefetch hint encodings
  typedef enum logic [1:0] {
    HINT_L0  = 2'b00,
    HINT_L1  = 2'b01,
    HINT_L2  = 2'b10,
    HINT_NTA = 2'b11
  } cbe_hint_t;
  // Bus tracker sizing
  localparam int TXN_W      = 4;   // Width of transaction counts
  localparam int BNR_CYCLES = 2;   // Bus cycles per not-ready assertion
  localparam logic [TXN_W-1:0] BNR_THRESH = 4'h6;  // Near-full level
endpackage

// *** inc/cbe_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus tracker results toward the counting core
// ----------------------------------------------------------------
interface cbe_if;
  logic                      busTick;       // One core cycle per bus cycle
  logic [cbe_pkg::TXN_W-1:0] pendReads;     // Pending full-line reads
  logic                      bnrEvent;      // New not-ready assertion
  logic                      bnrActive;     // Not-ready driven now
  logic                      ownDrdyCycle;  // Bus cycle of own strobe
  logic                      anyDrdyCycle;  // Bus cycle of any strobe
  modport trk  (output busTick, pendReads, bnrEvent, bnrActive,
                ownDrdyCycle, anyDrdyCycle);
  modport core (input busTick, pendReads, bnrEvent, bnrActive,
                ownDrdyCycle, anyDrdyCycle);
endinterface

// *** logic/cbe_bus_tracker.sv ***
`timescale 1ns/1ps
module cbe_bus_tracker
  import cbe_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rstSyncN,
  input  wire logic               ce,
  // Core side, same clock
  input  wire logic               rdIssue,
  input  wire logic               rdCacheable,
  input  wire logic               rdLineDone,
  input  wire logic [TXN_W-1:0]   snoopPend,
  input  wire logic               ownDataValid,
  // Bus pins
  input  wire logic               busClkPin,
  input  wire logic               bnrPinIn,
  input  wire logic               drdyPinIn,
  output logic                    bnrOut,
  output logic                    bnrOe,
  output logic                    drdyOut,
  output logic                    drdyOe,
  // Results
  cbe_if.trk                      res
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] clkSync_q;   // Bus clock, third stage for edge detect
  logic [1:0] bnrSync_q;   // Not-ready from other agents
  logic [1:0] drdySync_q;  // Data strobe on the wire
  // Two stages before any logic looks at a pin
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      clkSync_q  <= 3'h0;
      bnrSync_q  <= 2'h0;
      drdySync_q <= 2'h0;
    end else if (ce) begin
      clkSync_q  <= {clkSync_q[1:0], busClkPin};
      bnrSync_q  <= {bnrSync_q[0], bnrPinIn};
      drdySync_q <= {drdySync_q[0], drdyPinIn};
    end
  end
  // ----------------------------------------------------------------
  // Bus cycle and transaction tracking
  // ----------------------------------------------------------------
  wire tick     = clkSync_q[1] & ~clkSync_q[2];  // Rising bus clock
  wire rdCount  = rdIssue & rdCacheable;         // Full-line cacheable only
  wire [TXN_W-1:0] txnLoad = res.pendReads + snoopPend;
  wire busBlocked = bnrSync_q[1] | bnrOut;       // Any agent holds it
  logic [TXN_W-1:0] pend_q;      // Pending full-line reads
  logic [1:0]       bnrLeft_q;   // Bus cycles of assertion left
  logic             tick_q;
  logic             bnrEv_q;
  logic             ownDrdy_q;
  logic             anyDrdy_q;
  // Pending from issue until whole line received
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pend_q <= '0;
    end else if (ce) begin
      pend_q <= pend_q + TXN_W'(rdCount & ~busBlocked) - TXN_W'(rdLineDone); // RULE7 RULE8
    end
  end
  // Not-ready drive, each assertion spans two bus cycles
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      bnrLeft_q <= 2'h0;
      bnrOut    <= 1'b0;
      bnrEv_q   <= 1'b0;
    end else if (ce) begin
      bnrEv_q <= 1'b0;
      if (tick) begin
        if (bnrLeft_q != 2'h0) begin
          bnrLeft_q <= bnrLeft_q - 2'h1;
          bnrOut    <= 1'b1; // RULE9
        end else if (!bnrOut && txnLoad >= BNR_THRESH) begin
          bnrLeft_q <= 2'(BNR_CYCLES - 1); // RULE10
          bnrOut    <= 1'b1;
          bnrEv_q   <= 1'b1; // RULE9
        end else begin
          bnrOut <= 1'b0;
        end
      end
    end
  end
  // Strobe while own data is on the wire, sampled per bus cycle
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      drdyOut   <= 1'b0;
      tick_q    <= 1'b0;
      ownDrdy_q <= 1'b0;
      anyDrdy_q <= 1'b0;
    end else if (ce) begin
      tick_q    <= tick;
      ownDrdy_q <= tick & drdyOut; // RULE13
      anyDrdy_q <= tick & (drdyOut | drdySync_q[1]); // RULE14
      if (tick) begin
        drdyOut <= ownDataValid; // RULE12
      end
    end
  end
  // Open-drain style pins: enable follows drive
  assign bnrOe  = bnrOut;
  assign drdyOe = drdyOut;
  assign res.busTick      = tick_q;
  assign res.pendReads    = pend_q;
  assign res.bnrEvent     = bnrEv_q;
  assign res.bnrActive    = busBlocked;
  assign res.ownDrdyCycle = ownDrdy_q;
  assign res.anyDrdyCycle = anyDrdy_q;
endmodule

// *** logic/cbe_event_counter.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Code 4B mask 01 counts level-0 total misses
// RULE2: Code 4B mask 02 counts level-1/2 total misses
// RULE3: Level-0 fills both caches; level-1/2 only second
// RULE4: Code 4C counts loads hitting in-flight prefetch line
// RULE5: Code 4E mask 10 counts all prefetch requests
// RULE6: Rejected requests retried later or dropped
// RULE7: Code 60 adds pending line reads each cycle
// RULE8: Only cacheable full-line reads are pending
// RULE9: Code 61 counts own two-cycle not-ready assertions
// RULE10: Assert not-ready when transactions near bus maximum
// RULE11: No agent issues while not-ready is asserted
// RULE12: Data sender asserts strobe each data cycle
// RULE13: Code 62 own mask counts own strobe cycles
// RULE14: Code 62 any mask counts any strobe cycles
// RULE15: Count only on exact code and mask match
module cbe_event_counter
  import cbe_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Software prefetch pipeline
  input  wire logic               pfExec,
  input  wire cbe_hint_t          pfHint,
  input  wire logic               pfMissAll,
  input  wire logic [25:0]        pfLine,
  input  wire logic               pfDone,
  output logic                    fillL2,
  output logic                    fillL1,
  // Loads to the first-level data cache
  input  wire logic               loadValid,
  input  wire logic [25:0]        loadLine,
  // First-level prefetcher
  input  wire logic               l1PfReq,
  input  wire logic [25:0]        l1PfLine,
  input  wire logic               l2Busy,
  output logic                    l2PfValid,
  output logic [25:0]             l2PfLine,
  // Bus request side
  input  wire logic               rdIssue,
  input  wire logic               rdCacheable,
  input  wire logic               rdLineDone,
  input  wire logic [TXN_W-1:0]   snoopPend,
  input  wire logic               ownDataValid,
  output logic                    issueAllowed,
  // Bus pins
  input  wire logic               busClkPin,
  input  wire logic               bnrPinIn,
  input  wire logic               drdyPinIn,
  output logic                    bnrOut,
  output logic                    bnrOe,
  output logic                    drdyOut,
  output logic                    drdyOe
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_q;  // Two-stage release of the reset
  logic       rstSyncN;   // Released reset for the rest
  // Assert at once, release after two edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];

  // ----------------------------------------------------------------
  // Bus tracker
  // ----------------------------------------------------------------
  cbe_if trk ();
  cbe_bus_tracker u_trk (
    .clk          (ref_clk),
    .rstSyncN     (rstSyncN),
    .ce           (ce),
    .rdIssue      (rdIssue),
    .rdCacheable  (rdCacheable),
    .rdLineDone   (rdLineDone),
    .snoopPend    (snoopPend),
    .ownDataValid (ownDataValid),
    .busClkPin    (busClkPin),
    .bnrPinIn     (bnrPinIn),
    .drdyPinIn    (drdyPinIn),
    .bnrOut       (bnrOut),
    .bnrOe        (bnrOe),
    .drdyOut      (drdyOut),
    .drdyOe       (drdyOe),
    .res          (trk.trk)
  );

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [31:0]        select_q;  // Event selection
  logic [COUNT_W-1:0] count_q;   // Event counter
  logic [COUNT_W-1:0] count_d;
  logic               wait_q;    // One wait state per access
  wire access   = avs_read | avs_write;
  wire commit   = access & ~wait_q;       // Edge where master samples
  wire hitSel   = (avs_address == OFS_SELECT);
  wire hitCnt   = (avs_address == OFS_COUNT);
  wire hitStat  = (avs_address == OFS_STATUS);
  wire wrSel    = commit & avs_write & hitSel;
  wire wrCnt    = commit & avs_write & hitCnt;
  wire [31:0] statusWord = {26'h0, trk.bnrActive, 1'b0, trk.pendReads};
  wire [31:0] readMux =
    hitSel  ? select_q :
    hitCnt  ? 32'(count_q) :
    hitStat ? statusWord : 32'h0000_0000;  // Unmapped reads as zero
  // Wait state toggles so every access completes in two cycles
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wait_q          <= 1'b1;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      wait_q          <= ~(access & wait_q);
      avs_waitrequest <= ~(access & wait_q);
      if (access & wait_q) begin
        avs_readdata <= readMux;
      end
    end
  end
  // Select register write
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      select_q <= SELECT_RST;
    end else if (ce && wrSel) begin
      select_q <= avs_writedata;
    end
  end

  // ----------------------------------------------------------------
  // Software prefetch fills
  // ----------------------------------------------------------------
  wire pfL0  = pfExec & (pfHint == HINT_L0);
  wire pfL12 = pfExec & ((pfHint == HINT_L1) | (pfHint == HINT_L2));
  // Fill targets per hint, pulsed the cycle after a prefetch that missed every level
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      fillL2 <= 1'b0;
      fillL1 <= 1'b0;
    end else if (ce) begin
      fillL2 <= (pfL0 | pfL12) & pfMissAll; // RULE3
      fillL1 <= pfL0 & pfMissAll; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // In-flight software prefetch line
  // ----------------------------------------------------------------
  logic        pendPf_q;    // A prefetch has started, not finished
  logic [25:0] pendLine_q;  // Its cache line
  // Track the latest started prefetch until its completion
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pendPf_q   <= 1'b0;
      pendLine_q <= 26'h000_0000;
    end else if (ce) begin
      if (pfExec & pfMissAll) begin
        pendPf_q   <= 1'b1;  // New start wins over completion
        pendLine_q <= pfLine;
      end else if (pfDone) begin
        pendPf_q <= 1'b0;
      end
    end
  end
  wire loadHitPf = loadValid & pendPf_q & (loadLine == pendLine_q); // RULE4

  // ----------------------------------------------------------------
  // First-level prefetcher with one retry slot
  // ----------------------------------------------------------------
  logic        retry_q;      // Rejected request held for resubmit
  logic [25:0] retryLine_q;
  wire sendNew   = l1PfReq & ~l2Busy;
  wire sendRetry = retry_q & ~l2Busy & ~l1PfReq;
  // Rejected request waits; a newer request drops the older one
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      retry_q     <= 1'b0;
      retryLine_q <= 26'h000_0000;
      l2PfValid   <= 1'b0;
      l2PfLine    <= 26'h000_0000;
    end else if (ce) begin
      l2PfValid <= sendNew | sendRetry;
      if (sendNew) begin
        l2PfLine <= l1PfLine;
      end else if (sendRetry) begin
        l2PfLine <= retryLine_q;
      end
      if (l1PfReq & l2Busy) begin
        retry_q     <= 1'b1; // RULE6
        retryLine_q <= l1PfLine;
      end else if (sendRetry | sendNew) begin
        retry_q <= 1'b0; // RULE6
      end
    end
  end

  // ----------------------------------------------------------------
  // Own bus issue permission
  // ----------------------------------------------------------------
  // Hold back own requests while any agent asserts not-ready
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      issueAllowed <= 1'b0;
    end else if (ce) begin
      issueAllowed <= ~trk.bnrActive; // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Event selection and increment
  // ----------------------------------------------------------------
  wire [7:0] selCode = select_q[SEL_CODE_LSB +: 8];
  wire [7:0] selMask = select_q[SEL_MASK_LSB +: 8];
  wire       selEn   = select_q[SEL_EN_BIT];
  // Each event matches only its exact code and mask pair
  wire mL0Miss  = (selCode == EV_PF_MISS)  & (selMask == UM_L0_MISS); // RULE15
  wire mL12Miss = (selCode == EV_PF_MISS)  & (selMask == UM_L12_MISS); // RULE15
  wire mLoadHit = (selCode == EV_LOAD_HIT) & (selMask == UM_NONE); // RULE15
  wire mPfReq   = (selCode == EV_L1_PFREQ) & (selMask == UM_PF_REQ); // RULE15
  wire mOutOwn  = (selCode == EV_RD_OUTST) & (selMask == UM_AGENT_OWN);
  wire mOutAny  = (selCode == EV_RD_OUTST) & (selMask == UM_AGENT_ANY);
  wire mBnr     = (selCode == EV_BNR_DRV)  & (selMask == UM_AGENT_OWN);
  wire mDrdyOwn = (selCode == EV_DATA_READY_STROBE_CYC) & (selMask == UM_AGENT_OWN);
  wire mDrdyAny = (selCode == EV_DATA_READY_STROBE_CYC) & (selMask == UM_AGENT_ANY);
  // Increment per event source
  wire [TXN_W-1:0] incL0   = TXN_W'(mL0Miss & pfL0 & pfMissAll); // RULE1
  wire [TXN_W-1:0] incL12  = TXN_W'(mL12Miss & pfL12 & pfMissAll); // RULE2
  wire [TXN_W-1:0] incLoad = TXN_W'(mLoadHit & loadHitPf); // RULE4
  wire [TXN_W-1:0] incPf   = TXN_W'(mPfReq & l1PfReq); // RULE5
  wire [TXN_W-1:0] incOut  = (mOutOwn | mOutAny) ? trk.pendReads : '0; // RULE7
  wire [TXN_W-1:0] incBnr  = TXN_W'(mBnr & trk.bnrEvent); // RULE9
  wire [TXN_W-1:0] incDo   = TXN_W'(mDrdyOwn & trk.ownDrdyCycle); // RULE13
  wire [TXN_W-1:0] incDa   = TXN_W'(mDrdyAny & trk.anyDrdyCycle); // RULE14
  wire [TXN_W-1:0] incSum  = incL0 | incL12 | incLoad | incPf | incOut
                           | incBnr | incDo | incDa;
  // Software write loads the counter, else add when enabled
  always_comb begin
    count_d = count_q;
    if (wrCnt) begin
      count_d = COUNT_W'(avs_writedata);
    end else if (selEn) begin
      count_d = count_q + COUNT_W'(incSum); // RULE15
    end
  end
  // Counter register
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      count_q <= '0;
    end else if (ce) begin
      count_q <= count_d;
    end
  end
endmodule

// *** sim/cbe_event_counter_props.sv ***
`timescale 1ns/1ps
// ----------------------------------
// Port checks for the counting block
// ----------------------------------
module cbe_event_counter_props (
  // Clock and control
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        ce,
  // Prefetch side
  input wire logic        pfExec,
  input wire logic [1:0]  pfHint,
  input wire logic        pfMissAll,
  input wire logic        fillL2,
  input wire logic        fillL1,
  input wire logic        l1PfReq,
  input wire logic [25:0] l1PfLine,
  input wire logic        l2Busy,
  input wire logic        l2PfValid,
  input wire logic [25:0] l2PfLine,
  // Bus side
  input wire logic        issueAllowed,
  input wire logic        bnrOut,
  input wire logic        bnrOe,
  input wire logic        drdyOut,
  input wire logic        drdyOe
);
  import cbe_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Prefetch that missed every level, clock running
  wire logic pfMiss = ce && pfExec && pfMissAll;
  AST_FILL_L0: assert property (pfMiss && pfHint == HINT_L0 |=> fillL1 && fillL2)
    else $error("level-0 miss did not fill both caches");
  AST_FILL_L12: assert property (
    pfMiss && pfHint inside {HINT_L1, HINT_L2} |=> fillL2 && !fillL1)
    else $error("level-1/2 miss filled the wrong caches");
  AST_NO_FILL: assert property (ce && !(pfExec && pfMissAll) |=> !fillL1 && !fillL2)
    else $error("fill without a missing prefetch");
  AST_PF_SEND: assert property (
    ce && l1PfReq && !l2Busy |=> l2PfValid && l2PfLine == $past(l1PfLine))
    else $error("accepted prefetch request not passed on");
  AST_PF_BUSY: assert property (ce && l2Busy |=> !l2PfValid)
    else $error("request sent while second level busy");
  AST_BNR_OE: assert property (bnrOe == bnrOut)
    else $error("not-ready enable differs from drive");
  AST_DATA_READY_STROBE_OE: assert property (drdyOe == drdyOut)
    else $error("strobe enable differs from drive");
  AST_BNR_LEN: assert property ($rose(bnrOut) |-> bnrOut [*8])
    else $error("not-ready assertion shorter than two bus cycles");
  AST_BNR_STALL: assert property (bnrOut && $past(bnrOut) |-> !issueAllowed)
    else $error("issue allowed while not-ready driven");
endmodule

bind cbe_event_counter cbe_event_counter_props u_props (
  .ref_clk, .rstn, .ce, .pfExec, .pfHint, .pfMissAll, .fillL2, .fillL1, .l1PfReq,
  .l1PfLine, .l2Busy, .l2PfValid, .l2PfLine, .issueAllowed, .bnrOut, .bnrOe,
  .drdyOut, .drdyOe
);

// *** sim/cbe_bus_agent.sv ***
`timescale 1ns/1ps
// -------------------------------------
// Other agents on the shared system bus
// -------------------------------------
module cbe_bus_agent #(
  parameter int SEND_CYCLES = 4  // Bus cycles per data burst
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Device pin drive
  input  wire logic bnrOut,
  input  wire logic bnrOe,
  input  wire logic drdyOut,
  input  wire logic drdyOe,
  // Burst request, one-cycle pulse
  input  wire logic sendReq,
  // Resolved bus pins
  output logic      busClkPin,
  output logic      bnrPinIn,
  output logic      drdyPinIn
);
  logic [1:0] divQ;   // Core cycles within a bus cycle
  logic       pendQ;  // Burst waiting to start
  logic [3:0] leftQ;  // Bus cycles still to send
  logic       drdyQ;  // Strobe of this agent
  // Bus clock runs free at a quarter of the core rate
  assign busClkPin = divQ[1];
  // Wired-OR pins with pull-down: released lines read low
  assign bnrPinIn  = bnrOe & bnrOut;
  assign drdyPinIn = (drdyOe & drdyOut) | drdyQ;
  // New burst only while not-ready is released
  wire logic startBurst = pendQ && leftQ == 4'h0 && divQ != 2'h3 && !bnrPinIn;
  // Burst sequencer, strobe changes on bus clock fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {divQ, pendQ, leftQ, drdyQ} <= 8'h00;
    end else begin
      divQ  <= divQ + 2'h1;
      pendQ <= sendReq | (pendQ & !startBurst);
      if (divQ == 2'h3) begin
        drdyQ <= (leftQ != 4'h0);
        leftQ <= (leftQ != 4'h0) ? leftQ - 4'h1 : 4'h0;
      end else if (startBurst) begin
        leftQ <= 4'(SEND_CYCLES);
      end
    end
  end
endmodule

// *** sim/tb_cache_bus_event_counting.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin \
  numChecks++; \
  if ((sn) !== (ex)) begin \
    mismatches++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, sn); \
  end \
end
// ----------------------------------
// Bench for the event counting block
// ----------------------------------
module tb_cache_bus_event_counting;
  import cbe_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mask;
    logic [3:0] kind;
    logic [7:0] cnt;
  } cbe_row_t;
  // Selection, stimulus kind, expected count
  localparam cbe_row_t ROWS [11] = '{
    '{EV_PF_MISS, UM_L0_MISS, 4'h0, 8'h03},
    '{EV_PF_MISS, UM_L0_MISS, 4'h7, 8'h00},
    '{EV_PF_MISS, UM_L0_MISS, 4'h1, 8'h00},
    '{EV_PF_MISS, UM_L12_MISS, 4'h1, 8'h03},
    '{EV_PF_MISS, UM_L12_MISS, 4'h2, 8'h03},
    '{EV_PF_MISS, UM_L12_MISS, 4'h0, 8'h00},
    '{EV_LOAD_HIT, UM_NONE, 4'h3, 8'h03},
    '{EV_LOAD_HIT, UM_L0_MISS, 4'h3, 8'h00},
    '{EV_L1_PFREQ, UM_PF_REQ, 4'h4, 8'h03},
    '{EV_L1_PFREQ, UM_PF_REQ, 4'h5, 8'h03},
    '{EV_L1_PFREQ, UM_NONE, 4'h4, 8'h00}
  };
  // Design inputs
  logic        ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        pfExec = 1'b0, pfMissAll = 1'b0, pfDone = 1'b0, loadValid = 1'b0;
  logic        l1PfReq = 1'b0, l2Busy = 1'b0, rdIssue = 1'b0, rdCacheable = 1'b0;
  logic        rdLineDone = 1'b0, ownDataValid = 1'b0, sendReq = 1'b0;
  logic [3:0]  avs_address = 4'h0, snoopPend = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [25:0] pfLine = 26'h2ABCDE, loadLine = 26'h2ABCDE, l1PfLine = 26'h0;
  cbe_hint_t   pfHint = HINT_L0;
  // Design outputs and bus pins
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, fillL2, fillL1, l2PfValid, issueAllowed;
  logic [25:0] l2PfLine;
  logic        busClkPin, bnrPinIn, drdyPinIn, bnrOut, bnrOe, drdyOut, drdyOe;
  // Bench state
  int          mismatches = 0;
  int          numChecks = 0;
  logic [31:0] rd, base;

  always #2.5 ref_clk = ~ref_clk;

  cbe_event_counter #(.COUNT_W(32)) dut (
    .ref_clk, .rstn, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .pfExec, .pfHint, .pfMissAll, .pfLine, .pfDone,
    .fillL2, .fillL1, .loadValid, .loadLine, .l1PfReq, .l1PfLine, .l2Busy, .l2PfValid,
    .l2PfLine, .rdIssue, .rdCacheable, .rdLineDone, .snoopPend, .ownDataValid,
    .issueAllowed, .busClkPin, .bnrPinIn, .drdyPinIn, .bnrOut, .bnrOe, .drdyOut, .drdyOe
  );
  cbe_bus_agent agent (
    .clk(ref_clk), .rstn, .bnrOut, .bnrOe, .drdyOut, .drdyOe, .sendReq, .busClkPin,
    .bnrPinIn, .drdyPinIn
  );

  // Verdict and end of run
  task automatic final_report;
    $display("Checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One register access, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      final_report();
    end
    {avs_write, avs_read} <= 2'h0;
  endtask

  function automatic logic [31:0] sel(input logic [7:0] c, input logic [7:0] m);
    return (32'h1 << SEL_EN_BIT) | (32'(m) << SEL_MASK_LSB) | (32'(c) << SEL_CODE_LSB);
  endfunction

  // One-cycle pulse of the chosen pipeline event
  task automatic fire(input int k);
    @(posedge ref_clk);
    pfHint <= (k == 7) ? HINT_L0 : cbe_hint_t'(k[1:0]);
    pfMissAll <= (k != 7);
    if (k >= 4) l1PfLine <= l1PfLine + 26'h1;
    {pfExec, loadValid, l1PfReq, l2Busy, pfDone, rdIssue, rdCacheable, rdLineDone} <=
      {k < 3 || k == 7, k == 3, k == 4 || k == 5, k == 5, k == 6, k == 8 || k == 9,
       k == 8, k == 10};
    @(posedge ref_clk);
    {pfExec, loadValid, l1PfReq, l2Busy, pfDone, rdIssue, rdCacheable, rdLineDone} <= 8'h0;
  endtask

  // Bounded wait for a send (0) or a not-ready drive (1)
  task automatic wait_hi(input int w);
    int n;
    for (n = 0; n < 50 && (w == 0 ? l2PfValid : bnrOut) !== 1'b1; n++) @(posedge ref_clk);
    if ((w == 0 ? l2PfValid : bnrOut) !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic count_is(input logic [31:0] e, input int w);
    repeat (w) @(posedge ref_clk);
    xfer(1'b0, OFS_COUNT, 32'h0);
    `CHK("count", e, rd)
  endtask

  // Own strobe (oth low) or a burst by another agent
  task automatic data_ready_strobe_case(input logic [7:0] m, input logic oth, input logic [31:0] e);
    xfer(1'b1, OFS_SELECT, sel(EV_DATA_READY_STROBE_CYC, m));
    xfer(1'b1, OFS_COUNT, 32'h0);
    {sendReq, ownDataValid} <= {oth, !oth};
    @(posedge ref_clk);
    sendReq <= 1'b0;
    repeat (11) @(posedge ref_clk);
    ownDataValid <= 1'b0;
    count_is(e, 40);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    `CHK("wait in reset", 1'b1, avs_waitrequest)
    `CHK("data in reset", 32'h0, avs_readdata)
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    xfer(1'b0, OFS_SELECT, 32'h0);
    `CHK("select reset", SELECT_RST, rd)
    xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
    xfer(1'b0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    foreach (ROWS[i]) begin
      xfer(1'b1, OFS_SELECT, sel(ROWS[i].code, ROWS[i].mask));
      xfer(1'b1, OFS_COUNT, 32'h0);
      if (ROWS[i].kind == 4'h3) fire(0);
      repeat (3) fire(int'(ROWS[i].kind));
      if (ROWS[i].kind == 4'h3) fire(6);
      if (ROWS[i].kind == 4'h3) fire(3);
      count_is(32'(ROWS[i].cnt), 4);
    end
    fire(5);
    wait_hi(0);
    `CHK("retry line", l1PfLine, l2PfLine)
    xfer(1'b1, OFS_SELECT, sel(EV_RD_OUTST, UM_AGENT_OWN));
    fire(8);
    fire(8);
    fire(9);
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK("pending", 4'h2, rd[3:0])
    xfer(1'b0, OFS_COUNT, 32'h0);
    base = rd;
    xfer(1'b0, OFS_COUNT, 32'h0);
    `CHK("pending sum", base + 32'h6, rd)
    fire(10);
    fire(10);
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK("drained", 4'h0, rd[3:0])
    xfer(1'b1, OFS_SELECT, sel(EV_BNR_DRV, UM_AGENT_OWN));
    xfer(1'b1, OFS_COUNT, 32'h0);
    snoopPend <= 4'h5;
    count_is(32'h0, 40);
    snoopPend <= 4'h6;
    wait_hi(1);
    snoopPend <= 4'h0;
    count_is(32'h1, 30);
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK("not-ready idle", 1'b0, rd[5])
    data_ready_strobe_case(UM_AGENT_ANY, 1'b1, 32'h4);
    data_ready_strobe_case(UM_AGENT_OWN, 1'b1, 32'h0);
    data_ready_strobe_case(UM_AGENT_OWN, 1'b0, 32'h3);
    data_ready_strobe_case(UM_AGENT_ANY, 1'b0, 32'h3);
    final_report();
  end
endmodule
